// ===== logic/mts_params.svh
// constants for the module test sequencer
// assumes inclusion from the package and design modules
`ifndef MTS_PARAMS_SVH
`define MTS_PARAMS_SVH
`define MTS_IN_WORDS      6
`define MTS_OUT_WORDS     4
`define MTS_WORD_W        16
`define MTS_STIM_W        62
`define MTS_TIME_W        6
`define MTS_TIME_WORDS    4
`define MTS_RESP_W        44
`define MTS_GATES         5
`define MTS_LAUNCH_STATE  3'h6
`define MTS_SEQ_MIN_KHZ   500
`define MTS_SEQ_MAX_KHZ   10000
`define MTS_CLK_KHZ       10000
`define MTS_DIV_DEFAULT   8'h00
`endif

// ===== logic/mts_pkg.sv
// shared types for the module test sequencer
// assumes mts_params.svh is on the include path
`include "mts_params.svh"
package mts_pkg;
  typedef logic [`MTS_WORD_W-1:0] mts_word_t;
  typedef logic [`MTS_TIME_W-1:0] mts_time_t;
  typedef enum logic [3:0] {
    MTS_LOAD = 4'h1,
    MTS_SEQ  = 4'h2,
    MTS_READ = 4'h4,
    MTS_DONE = 4'h8
  } mts_state_e;
endpackage

// ===== logic/mts_sync_if.sv
// carrier for synchronised host strobes between top and conditioner
// assumes a single clock domain
`timescale 1ns/10ps
interface mts_sync_if;
  logic init_pulse;
  logic step_pulse;
  modport src (output init_pulse, output step_pulse);
  modport dst (input init_pulse, input step_pulse);
endinterface

// ===== logic/mts_strobe_cond.sv
// synchronises the host strobes and emits one-cycle rising-edge pulses
// assumes strobe pins are asynchronous to CLK
`timescale 1ns/10ps
module mts_strobe_cond (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic init_strobe,
  input  wire logic step_strobe,
  mts_sync_if.src   sync
);
  logic [1:0] init_sy_r;
  logic [1:0] step_sy_r;
  logic       init_old_r;
  logic       step_old_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      init_sy_r <= 2'h0;
      step_sy_r <= 2'h0;
    end else begin
      init_sy_r <= {init_sy_r[0], init_strobe};
      step_sy_r <= {step_sy_r[0], step_strobe};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      init_old_r <= 1'b0;
      step_old_r <= 1'b0;
    end else begin
      init_old_r <= init_sy_r[1];
      step_old_r <= step_sy_r[1];
    end
  end

  assign sync.init_pulse = init_sy_r[1] & ~init_old_r;
  assign sync.step_pulse = step_sy_r[1] & ~step_old_r;
endmodule

// ===== logic/mts_resp_mem.sv
// four-word response store with registered read data
// assumes a write of all words at once from the response latch
`timescale 1ns/10ps
`include "mts_params.svh"
module mts_resp_mem #(
  parameter int WIDTH = `MTS_WORD_W,
  parameter int DEPTH = `MTS_OUT_WORDS
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     wr_en,
  input  wire logic [WIDTH*DEPTH-1:0]   wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("mts_resp_mem: bad shape");
  end

  for (genvar g = 0; g < DEPTH; g++) begin : g_word
    always_ff @(posedge clk) begin
      if (!rstn) begin
        mem_r[g] <= '0;
      end else if (wr_en) begin
        mem_r[g] <= wr_data[g*WIDTH +: WIDTH];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule

// ===== logic/mts_top.sv
// module test sequencer: loads stimulus, sequences it, returns response
// assumes host strobes are async pins; module outputs are async pins
//
// What this block does
// - six sixteen-bit loads carry 86 bits
// - split into 62 stimulus, four timing words
// - timing words set start, gating, sampling
// - sequencing rate adjustable 500 kHz to 10 MHz
// - 44-bit response returned as four words
// - init strobe clears all counters and control flops, not the input sync flops
// - counter decode enables one word latch per count 0-5, none at count 6
// - step latches bus into enabled word
// - second step advances input counter
// - seventh state fires one-shot launch pulse
// - launch falling edge sets run flop
// - two-bit selector muxes timing word one first
// - decode switch, counter, match into gate enables
// - each match before the end advances selector; switches mark end
// - end word latches response, starts output
// - output launch sets read request flop
// - output counter selects response word, first first
// - host step advances to next response word
`timescale 1ns/10ps
`include "mts_params.svh"
module mts_top
  import mts_pkg::*;
#(
  parameter int WORDS_IN = `MTS_IN_WORDS
) (
  input  wire logic                   CLK,
  input  wire logic                   RSTN,
  input  wire logic                   INIT_STROBE,
  input  wire logic                   STEP_STROBE,
  input  wire logic [`MTS_WORD_W-1:0] HOST_OUT_BUS,
  output logic      [`MTS_WORD_W-1:0] HOST_IN_BUS,
  output logic                        READ_REQUEST,
  input  wire logic [7:0]             SEQ_DIVIDE,
  input  wire logic [11:0]            GATE_SWITCH,
  input  wire logic [3:0]             END_SWITCH,
  input  wire logic [`MTS_RESP_W-1:0] MODULE_OUT,
  output logic      [`MTS_STIM_W-1:0] STIMULUS,
  output logic      [`MTS_GATES-1:0]  INPUT_GATE_ENABLE,
  output logic                        SEQ_RUNNING
);
  localparam int TOTAL_IN = WORDS_IN * `MTS_WORD_W;
  localparam int LOAD_BITS = `MTS_STIM_W + `MTS_TIME_WORDS * `MTS_TIME_W;

  initial begin
    if (WORDS_IN != `MTS_IN_WORDS || TOTAL_IN < LOAD_BITS)
      $error("mts_top: word count cannot hold the load");
  end

  mts_sync_if sync ();

  mts_strobe_cond u_cond (
    .clk         (CLK),
    .rstn        (RSTN),
    .init_strobe (INIT_STROBE),
    .step_strobe (STEP_STROBE),
    .sync        (sync)
  );

  // module outputs come from another domain: two flops before sampling
  logic [`MTS_RESP_W-1:0] mod_sy1_r;
  logic [`MTS_RESP_W-1:0] mod_sy2_r;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      mod_sy1_r <= '0;
      mod_sy2_r <= '0;
    end else begin
      mod_sy1_r <= MODULE_OUT;
      mod_sy2_r <= mod_sy1_r;
    end
  end

  // host bus and switch panel are async pins: two flops before any logic
  logic [`MTS_WORD_W-1:0] bus_sy1_r;
  logic [`MTS_WORD_W-1:0] bus_sy2_r;
  logic [7:0]             div_sy1_r;
  logic [7:0]             div_sy2_r;
  logic [11:0]            gsw_sy1_r;
  logic [11:0]            gsw_sy2_r;
  logic [3:0]             esw_sy1_r;
  logic [3:0]             esw_sy2_r;
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      bus_sy1_r <= '0;
      bus_sy2_r <= '0;
      div_sy1_r <= 8'h00;
      div_sy2_r <= 8'h00;
      gsw_sy1_r <= 12'h000;
      gsw_sy2_r <= 12'h000;
      esw_sy1_r <= 4'h0;
      esw_sy2_r <= 4'h0;
    end else begin
      bus_sy1_r <= HOST_OUT_BUS;
      bus_sy2_r <= bus_sy1_r;
      div_sy1_r <= SEQ_DIVIDE;
      div_sy2_r <= div_sy1_r;
      gsw_sy1_r <= GATE_SWITCH;
      gsw_sy2_r <= gsw_sy1_r;
      esw_sy1_r <= END_SWITCH;
      esw_sy2_r <= esw_sy1_r;
    end
  end

  logic       clr;
  logic       step;
  mts_state_e state_r;
  logic [1:0] out_cnt_r;
  assign clr  = sync.init_pulse;
  assign step = sync.step_pulse & (state_r != MTS_SEQ);

  // input control: counter plus half-step phase (latch, then advance)
  logic [2:0] in_cnt_r;
  logic       in_phase_r;
  logic [7:0] in_dec;
  logic [`MTS_WORD_W-1:0] in_word_r [`MTS_IN_WORDS];

  function automatic logic [7:0] dec3to8(input logic [2:0] v);
    dec3to8 = 8'h01 << v;
  endfunction

  assign in_dec = dec3to8(in_cnt_r);

  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      in_cnt_r   <= 3'h0;
      in_phase_r <= 1'b0;
    end else if (step && state_r == MTS_LOAD) begin
      in_phase_r <= ~in_phase_r;
      if (in_phase_r)
        in_cnt_r <= in_cnt_r + 3'h1;
    end
  end

  for (genvar w = 0; w < `MTS_IN_WORDS; w++) begin : g_in
    always_ff @(posedge CLK) begin
      if (!RSTN || clr) begin
        in_word_r[w] <= '0;
      end else if (step && state_r == MTS_LOAD && !in_phase_r &&
                   in_dec[w]) begin
        in_word_r[w] <= bus_sy2_r;
      end
    end
  end

  // split load into stimulus and timing
  logic [TOTAL_IN-1:0] load_flat;
  logic [`MTS_STIM_W-1:0] stim_reg;
  mts_time_t time_word [`MTS_TIME_WORDS];
  for (genvar w = 0; w < `MTS_IN_WORDS; w++) begin : g_flat
    assign load_flat[w*`MTS_WORD_W +: `MTS_WORD_W] = in_word_r[w];
  end
  assign stim_reg = load_flat[`MTS_STIM_W-1:0];
  for (genvar t = 0; t < `MTS_TIME_WORDS; t++) begin : g_time
    assign time_word[t] =
      load_flat[`MTS_STIM_W + t*`MTS_TIME_W +: `MTS_TIME_W];
  end

  logic launch_r;
  logic launch_seen_r;
  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      launch_r      <= 1'b0;
      launch_seen_r <= 1'b0;
    end else begin
      launch_r <= 1'b0;
      if (in_cnt_r == `MTS_LAUNCH_STATE && !launch_seen_r) begin
        launch_r      <= 1'b1;
        launch_seen_r <= 1'b1;
      end
    end
  end

  // divider makes sequencing tick from 10 MHz down to 500 kHz
  logic [7:0] div_cnt_r;
  logic       tick;
  logic [7:0] div_lim;
  localparam logic [7:0] DIV_MAX =
    8'((`MTS_CLK_KHZ / `MTS_SEQ_MIN_KHZ) - 1);
  assign div_lim = (div_sy2_r > DIV_MAX) ? DIV_MAX : div_sy2_r;
  assign tick    = (div_cnt_r >= div_lim);
  always_ff @(posedge CLK) begin
    if (!RSTN || clr || state_r != MTS_SEQ) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= tick ? 8'h00 : div_cnt_r + 8'h01;
    end
  end

  // launch falling edge sets run state
  logic launch_old_r;
  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      launch_old_r <= 1'b0;
    end else begin
      launch_old_r <= launch_r;
    end
  end

  logic [`MTS_TIME_W-1:0] seq_cnt_r;
  logic [1:0]             sel_r;
  mts_time_t              cmp_val;
  logic                   match;
  logic                   is_end;
  logic                   resp_latch;

  assign cmp_val = time_word[sel_r];
  // comparator ties timing words to events
  assign match   = tick && state_r == MTS_SEQ && seq_cnt_r == cmp_val;
  assign is_end  = esw_sy2_r[sel_r] || sel_r == 2'h3;
  assign resp_latch = match && is_end;

  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      state_r <= MTS_LOAD;
    end else begin
      unique case (state_r)
        MTS_LOAD: if (launch_old_r && !launch_r) state_r <= MTS_SEQ;
        MTS_SEQ:  if (resp_latch) state_r <= MTS_READ;
        MTS_READ: if (step && out_cnt_r == 2'h3) state_r <= MTS_DONE;
        MTS_DONE: state_r <= MTS_DONE;
        default:  state_r <= MTS_LOAD;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      seq_cnt_r <= '0;
    end else if (tick && state_r == MTS_SEQ) begin
      seq_cnt_r <= seq_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      sel_r <= 2'h0;
    end else if (match && !is_end) begin
      sel_r <= sel_r + 2'h1;
    end
  end

  // gate enables from switches, selector and match
  logic [`MTS_GATES-1:0] gate_r;
  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      gate_r <= '0;
    end else if (match) begin
      gate_r <= gate_r | (gsw_sy2_r[sel_r*3 +: 3] == 3'h0 ? 5'h00 :
                          5'(5'h01 << (gsw_sy2_r[sel_r*3 +: 3] - 3'h1)));
    end
  end

  logic req_r;
  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      req_r <= 1'b0;
    end else if (resp_latch) begin
      req_r <= 1'b1;
    end else if (step && state_r == MTS_READ && out_cnt_r == 2'h3) begin
      req_r <= 1'b0;
    end
  end

  // output counter starts at word one
  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      out_cnt_r <= 2'h0;
    end else if (step && state_r == MTS_READ) begin
      out_cnt_r <= out_cnt_r + 2'h1;
    end
  end

  // 44 bits in four sixteen-bit words
  logic [`MTS_OUT_WORDS*`MTS_WORD_W-1:0] resp_pad;
  logic [`MTS_WORD_W-1:0]                rd_word;
  assign resp_pad = {{(`MTS_OUT_WORDS*`MTS_WORD_W-`MTS_RESP_W){1'b0}},
                     mod_sy2_r};

  mts_resp_mem #(
    .WIDTH (`MTS_WORD_W),
    .DEPTH (`MTS_OUT_WORDS)
  ) u_resp (
    .clk     (CLK),
    .rstn    (RSTN & ~clr),
    .wr_en   (resp_latch),
    .wr_data (resp_pad),
    .rd_addr (out_cnt_r),
    .rd_data (rd_word)
  );

  always_ff @(posedge CLK) begin
    if (!RSTN || clr) begin
      HOST_IN_BUS  <= '0;
      READ_REQUEST <= 1'b0;
      STIMULUS     <= '0;
      INPUT_GATE_ENABLE <= '0;
      SEQ_RUNNING  <= 1'b0;
    end else begin
      HOST_IN_BUS  <= rd_word;
      READ_REQUEST <= req_r;
      STIMULUS     <= stim_reg;
      INPUT_GATE_ENABLE <= gate_r;
      SEQ_RUNNING  <= (state_r == MTS_SEQ);
    end
  end
endmodule

// ===== dv/mts_checker.sv
// port-level assertions for the module test sequencer
// assumes it is bound onto mts_top; one clock domain
`timescale 1ns/10ps
`include "mts_params.svh"
module mts_checker (
  input wire logic                   CLK,
  input wire logic                   RSTN,
  input wire logic                   INIT_STROBE,
  input wire logic                   STEP_STROBE,
  input wire logic                   READ_REQUEST,
  input wire logic [`MTS_STIM_W-1:0] STIMULUS,
  input wire logic [`MTS_GATES-1:0]  INPUT_GATE_ENABLE,
  input wire logic                   SEQ_RUNNING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [4:0] since_step_r;
  // saturating age of the last step edge, so launches can be traced to it
  always_ff @(posedge CLK) begin
    if (!RSTN || $rose(STEP_STROBE)) since_step_r <= 5'h00;
    else if (since_step_r != 5'h1f) since_step_r <= since_step_r + 5'h01;
  end
  property p_rst_clear;
    disable iff (1'b0) !RSTN |=> !SEQ_RUNNING && !READ_REQUEST &&
      INPUT_GATE_ENABLE == 5'h00 && STIMULUS == '0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared by reset");
  property p_init_clear;
    $rose(INIT_STROBE) |-> ##[1:6] (!SEQ_RUNNING && !READ_REQUEST &&
      INPUT_GATE_ENABLE == 5'h00 && STIMULUS == '0);
  endproperty
  a_init_clear: assert property (p_init_clear)
    else $error("init strobe did not clear state");
  property p_stim_hold;
    SEQ_RUNNING && $past(SEQ_RUNNING) |-> $stable(STIMULUS);
  endproperty
  a_stim_hold: assert property (p_stim_hold)
    else $error("stimulus changed during sequencing");
  property p_launch;
    $rose(SEQ_RUNNING) |-> since_step_r <= 5'h0a;
  endproperty
  a_launch: assert property (p_launch)
    else $error("sequencing started without a recent step");
  property p_load_step;
    !$stable(STIMULUS) && STIMULUS != '0 |-> since_step_r <= 5'h06;
  endproperty
  a_load_step: assert property (p_load_step)
    else $error("stimulus loaded without a step");
  property p_gate_rise;
    (INPUT_GATE_ENABLE & ~$past(INPUT_GATE_ENABLE)) != 5'h00
      |-> $past(SEQ_RUNNING);
  endproperty
  a_gate_rise: assert property (p_gate_rise)
    else $error("gate enable rose outside sequencing");
  property p_gate_keep;
    SEQ_RUNNING && !INIT_STROBE |=>
      (INPUT_GATE_ENABLE & $past(INPUT_GATE_ENABLE)) ==
      $past(INPUT_GATE_ENABLE);
  endproperty
  a_gate_keep: assert property (p_gate_keep)
    else $error("gate enable dropped during sequencing");
  property p_req_after;
    $rose(READ_REQUEST) |-> !SEQ_RUNNING;
  endproperty
  a_req_after: assert property (p_req_after)
    else $error("read request while sequencing");
  property p_req_hold;
    READ_REQUEST && !INIT_STROBE && since_step_r > 5'h04 |=> READ_REQUEST;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("read request dropped without a step");
  cover property ($rose(READ_REQUEST));
  cover property ($rose(SEQ_RUNNING));
  cover property (INPUT_GATE_ENABLE == 5'h13);
endmodule
bind mts_top mts_checker u_chk (
  .CLK(CLK), .RSTN(RSTN), .INIT_STROBE(INIT_STROBE),
  .STEP_STROBE(STEP_STROBE), .READ_REQUEST(READ_REQUEST),
  .STIMULUS(STIMULUS), .INPUT_GATE_ENABLE(INPUT_GATE_ENABLE),
  .SEQ_RUNNING(SEQ_RUNNING)
);

// ===== dv/mts_host_model.sv
// host side: parallel card with two strobes and a 16-bit bus pair
// assumes the bench calls its tasks; strobes held long for the syncs
`timescale 1ns/10ps
module mts_host_model (
  input  wire logic        CLK,
  output logic             INIT_STROBE,
  output logic             STEP_STROBE,
  output logic [15:0]      HOST_OUT_BUS,
  input  wire logic [15:0] HOST_IN_BUS
);
  initial begin
    INIT_STROBE = 1'b0;
    STEP_STROBE = 1'b0;
    HOST_OUT_BUS = 16'h5a5a;
  end
  task automatic pulse_strobe(input bit init);
    @(posedge CLK);
    #5;
    if (init) INIT_STROBE = 1'b1;
    else STEP_STROBE = 1'b1;
    repeat (4) @(posedge CLK);
    #5;
    INIT_STROBE = 1'b0;
    STEP_STROBE = 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  task automatic load_word(input logic [15:0] w);
    @(posedge CLK);
    #5;
    HOST_OUT_BUS = w;
    pulse_strobe(1'b0);
    // released bus shows the inverted word, never the old word
    #5;
    HOST_OUT_BUS = ~w;
    pulse_strobe(1'b0);
  endtask
  task automatic read_word(output logic [15:0] w);
    @(posedge CLK);
    #5;
    w = HOST_IN_BUS;
    pulse_strobe(1'b0);
  endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench for the module test sequencer
// assumes host model and checker files compiled alongside the design
`timescale 1ns/10ps
module testbench;
  import mts_pkg::*;
  logic        CLK, RSTN, INIT_STROBE, STEP_STROBE, READ_REQUEST, SEQ_RUNNING;
  logic [15:0] HOST_OUT_BUS, HOST_IN_BUS;
  logic [7:0]  SEQ_DIVIDE;
  logic [11:0] GATE_SWITCH;
  logic [3:0]  END_SWITCH;
  logic [43:0] MODULE_OUT;
  logic [61:0] STIMULUS;
  logic [4:0]  INPUT_GATE_ENABLE;
  int          err_count, checks, cycles, run_cnt;
  mts_top #(.WORDS_IN(6)) dut (
    .CLK(CLK), .RSTN(RSTN), .INIT_STROBE(INIT_STROBE),
    .STEP_STROBE(STEP_STROBE), .HOST_OUT_BUS(HOST_OUT_BUS),
    .HOST_IN_BUS(HOST_IN_BUS), .READ_REQUEST(READ_REQUEST),
    .SEQ_DIVIDE(SEQ_DIVIDE), .GATE_SWITCH(GATE_SWITCH),
    .END_SWITCH(END_SWITCH), .MODULE_OUT(MODULE_OUT),
    .STIMULUS(STIMULUS), .INPUT_GATE_ENABLE(INPUT_GATE_ENABLE),
    .SEQ_RUNNING(SEQ_RUNNING));
  mts_host_model host (
    .CLK(CLK), .INIT_STROBE(INIT_STROBE), .STEP_STROBE(STEP_STROBE),
    .HOST_OUT_BUS(HOST_OUT_BUS), .HOST_IN_BUS(HOST_IN_BUS));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (SEQ_RUNNING === 1'b1) run_cnt++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic wait_for(input bit run);
    int n;
    n = 0;
    while ((run ? SEQ_RUNNING : READ_REQUEST) !== 1'b1 && n < 3000) begin
      @(posedge CLK);
      #5;
      n++;
    end
  endtask
  task automatic load(input logic [61:0] st, input logic [23:0] tw);
    logic [95:0] v;
    v = {10'h000, tw, st};
    host.pulse_strobe(1'b1);
    for (int i = 0; i < 6; i++) host.load_word(v[16*i +: 16]);
  endtask
  task automatic run_test(input logic [61:0] st, input logic [23:0] tw,
      input logic [11:0] gs, input logic [3:0] es, input logic [7:0] dv,
      input logic [4:0] eg, input int te, input logic [43:0] mo);
    logic [63:0] r;
    logic [15:0] w;
    @(posedge CLK);
    #5;
    GATE_SWITCH = gs;
    END_SWITCH = es;
    SEQ_DIVIDE = dv;
    MODULE_OUT = mo;
    run_cnt = 0;
    load(st, tw);
    wait_for(1'b1);
    check(STIMULUS, st);
    check(SEQ_RUNNING, 1'b1);
    host.pulse_strobe(1'b0);
    check(STIMULUS, st);
    wait_for(1'b0);
    #5;
    MODULE_OUT = ~mo;
    check(READ_REQUEST, 1'b1);
    check(SEQ_RUNNING, 1'b0);
    check(INPUT_GATE_ENABLE, eg);
    check(run_cnt >= te * (dv + 1) && run_cnt <= (te + 3) * (dv + 1) + 4,
      1'b1);
    r = {20'h00000, mo};
    repeat (3) @(posedge CLK);
    for (int i = 0; i < 4; i++) begin
      host.read_word(w);
      check(w, r[16*i +: 16]);
    end
  endtask
  initial begin
    RSTN = 1'b0;
    SEQ_DIVIDE = 8'h00;
    GATE_SWITCH = 12'h000;
    END_SWITCH = 4'h0;
    MODULE_OUT = 44'h000_0000_0000;
    repeat (20) @(posedge CLK);
    #5;
    RSTN = 1'b1;
    @(posedge CLK);
    check({READ_REQUEST, SEQ_RUNNING, INPUT_GATE_ENABLE}, 7'h00);
    check(STIMULUS, 62'h0);
    run_test(62'h2aaa_5555_f0f0_1234, {6'h32, 6'h2d, 6'h28, 6'h14},
      12'h003, 4'h2, 8'h00, 5'h04, 40, 44'habc_1234_5678);
    run_test(62'h1555_aaaa_0f0f_edcb, {6'h1e, 6'h19, 6'h0f, 6'h08},
      12'h151, 4'h0, 8'h02, 5'h13, 30, 44'h321_fedc_ba98);
    // init in mid-run must abandon the test
    load(62'h0123_4567_89ab_cdef, {6'h3f, 6'h3e, 6'h3d, 6'h3c});
    wait_for(1'b1);
    host.pulse_strobe(1'b1);
    check({READ_REQUEST, SEQ_RUNNING, INPUT_GATE_ENABLE}, 7'h00);
    check(STIMULUS, 62'h0);
    give_verdict();
  end
endmodule
